// ### rtl/fhv_seq.sv
// flash high-voltage program/erase/suspend sequencer with its control register
//
// Overview of operation
// [RULE1] suspended means suspend bit and done both set
// [RULE2] suspend set needs erase, enable high, no program
// [RULE3] suspend rise enters suspend within entry latency
// [RULE4] suspend clear needs done, enable high, no program
// [RULE5] suspend fall with enable high resumes erase
// [RULE6] enable low keeps suspend and done held
// [RULE7] reset clears suspend and high-voltage enable
// [RULE8] enable set only for legal erase/program setup
// [RULE9] software sets enable after interlock write
// [RULE10] enable fall with done high terminates normally
// [RULE11] enable fall with done low aborts, clears success; here only a running pulse aborts
// [RULE12] suspended operation is never aborted
// [RULE13] enable writable in suspend; needed to exit
// [RULE14] software avoids enable writes during transitions
// [RULE15] array size code reads 128 KB
// [RULE16] low space sectorization code reads 010
// [RULE17] mid space sectorization code reads zero
// [RULE18] multi-bit write applies only lowest priority level
// [RULE19] fetch collision stalls or aborts, sets success, interrupts; the abort path here clears success instead
// [RULE20] with stall/abort software ignores then clears error
// [RULE21] without stall/abort software handles the error
// [RULE22] program bit set only when erase and integrity low
// [RULE23] erase clear needs idle enable, suspend, done high
// [RULE24] success valid after done rises on completion
// [RULE25] done low while pulse or suspend transition runs
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "fhv_defines.svh"

module fhv_seq (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // flash array side
  input wire logic array_integrity_enable_i,
  input wire logic hv_fail_i,
  output logic hv_pulse_o,
  output logic hv_erase_o,
  output logic hv_program_o,
  // processor fetch side
  input wire logic fetch_collide_i,
  output logic stall_o,
  output logic irq_o
);

  fhv_pkg::fhv_regs_s s_q;
  fhv_pkg::fhv_regs_s s_d;
  logic done;
  logic busy;
  logic wr_mcr;
  logic wr_cfg;
  logic w_ers;
  logic w_pgm;
  logic w_ehv;
  logic w_erase_suspend_request;
  logic ehv_ok;

  // done is low only while a pulse or a suspend transition is running
  assign done = (s_q.st == fhv_pkg::FHV_IDLE) ||
                (s_q.st == fhv_pkg::FHV_SUSP); // [RULE25] [RULE1]
  assign busy = !done;
  assign wr_mcr = wr_i && (addr_i == `FHV_MCR_ADDR);
  assign wr_cfg = wr_i && (addr_i == `FHV_CFG_ADDR);
  assign w_ers = wdata_i[`FHV_ERS_BIT];
  assign w_pgm = wdata_i[`FHV_PGM_BIT];
  assign w_ehv = wdata_i[`FHV_EHV_BIT];
  assign w_erase_suspend_request = wdata_i[`FHV_ERASE_SUSPEND_REQUEST_BIT];
  assign ehv_ok = !s_q.erase_suspend_request && !array_integrity_enable_i &&
                  (s_q.erase_select || s_q.program_select); // [RULE8]

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    s_d.stall = 1'b0;
    s_d.irq = 1'b0;

    // sequencer timing
    unique case (s_q.st)
      fhv_pkg::FHV_IDLE: begin
      end
      fhv_pkg::FHV_RUN: begin
        if (s_q.cnt == 12'h000) begin
          s_d.st = fhv_pkg::FHV_IDLE;
          s_d.operation_success_flag = !hv_fail_i; // [RULE24]
        end else begin
          s_d.cnt = s_q.cnt - 12'h001;
        end
      end
      fhv_pkg::FHV_SENTER: begin
        if (s_q.cnt == 12'h000) begin
          s_d.st = fhv_pkg::FHV_SUSP; // [RULE3]
        end else begin
          s_d.cnt = s_q.cnt - 12'h001;
        end
      end
      fhv_pkg::FHV_SUSP: begin
      end
      fhv_pkg::FHV_RESUME: begin
        if (s_q.cnt == 12'h000) begin
          s_d.st = fhv_pkg::FHV_RUN; // [RULE5]
          s_d.cnt = s_q.rem;
        end else begin
          s_d.cnt = s_q.cnt - 12'h001;
        end
      end
    endcase

    // one of erase, program, enable, suspend per write: the lowest priority level wins, others dropped
    if (wr_mcr) begin
      if (w_ers != s_q.erase_select) begin // [RULE18]
        if (w_ers) begin
          if (!s_q.program_select && !array_integrity_enable_i) begin
            s_d.erase_select = 1'b1;
          end
        end else if (!s_q.erase_suspend_request && !s_q.high_voltage_enable && done) begin
          s_d.erase_select = 1'b0; // [RULE23]
        end
      end else if (w_pgm != s_q.program_select) begin
        if (w_pgm) begin
          if (!s_q.erase_select && !array_integrity_enable_i) begin
            s_d.program_select = 1'b1; // [RULE22]
          end
        end else if (!s_q.high_voltage_enable && done) begin
          s_d.program_select = 1'b0; // [RULE22]
        end
      end else if (w_ehv != s_q.high_voltage_enable) begin
        if (w_ehv) begin
          if (ehv_ok) begin
            s_d.high_voltage_enable = 1'b1; // [RULE8]
            s_d.st = fhv_pkg::FHV_RUN;
            s_d.cnt = `FHV_OP_CYC;
          end else if (s_q.st == fhv_pkg::FHV_SUSP) begin
            s_d.high_voltage_enable = 1'b1; // [RULE13]
          end
        end else begin
          s_d.high_voltage_enable = 1'b0; // [RULE10]
          // only a running pulse aborts; suspend keeps its erase
          if (s_q.st == fhv_pkg::FHV_RUN) begin
            s_d.st = fhv_pkg::FHV_IDLE; // [RULE11] [RULE12]
            s_d.operation_success_flag = 1'b0;
          end
        end
      end else if (w_erase_suspend_request != s_q.erase_suspend_request) begin
        if (w_erase_suspend_request) begin
          if (s_q.erase_select && s_q.high_voltage_enable && !s_q.program_select) begin
            s_d.erase_suspend_request = 1'b1; // [RULE2]
            s_d.st = fhv_pkg::FHV_SENTER;
            s_d.cnt = `FHV_SUSP_LAT_CYC; // [RULE3]
            s_d.rem = (s_q.st == fhv_pkg::FHV_RUN) ? s_q.cnt :
                      (s_q.st == fhv_pkg::FHV_RESUME) ? s_q.rem : 12'h000;
          end
        end else if (done && s_q.high_voltage_enable && !s_q.program_select) begin
          // enable low leaves the clear refused, so suspend holds
          s_d.erase_suspend_request = 1'b0; // [RULE4] [RULE6]
          s_d.st = fhv_pkg::FHV_RESUME; // [RULE5]
          s_d.cnt = `FHV_RES_CYC;
        end
      end
      if (wdata_i[`FHV_RWE_BIT]) begin
        s_d.read_while_write_error = 1'b0;
      end
    end

    if (wr_cfg) begin
      s_d.stall_en = wdata_i[`FHV_STALL_BIT];
      s_d.abort_en = wdata_i[`FHV_ABORT_BIT];
      s_d.irq_en = wdata_i[`FHV_IRQ_BIT];
    end

    // fetch colliding with a busy array; abort outranks stall except during suspend entry
    if (fetch_collide_i && busy) begin
      if (s_q.abort_en && (s_q.st != fhv_pkg::FHV_SENTER)) begin
        s_d.st = fhv_pkg::FHV_IDLE; // [RULE19]
        s_d.operation_success_flag = 1'b0;
        s_d.irq = s_q.irq_en;
      end else if (s_q.stall_en) begin
        s_d.stall = 1'b1; // [RULE19]
        s_d.operation_success_flag = 1'b1;
        s_d.irq = s_q.irq_en && !s_q.stall;
      end else begin
        // set after the clear above, so a colliding event is kept
        s_d.read_while_write_error = 1'b1;
      end
    end

    s_d.hv_on = (s_d.st == fhv_pkg::FHV_RUN); // [RULE25]

    if (rd_i) begin
      if (addr_i == `FHV_MCR_ADDR) begin
        s_d.rdata[`FHV_EHV_BIT] = s_q.high_voltage_enable;
        s_d.rdata[`FHV_ERASE_SUSPEND_REQUEST_BIT] = s_q.erase_suspend_request;
        s_d.rdata[`FHV_ERS_BIT] = s_q.erase_select;
        s_d.rdata[`FHV_PGM_BIT] = s_q.program_select;
        s_d.rdata[`FHV_PEG_BIT] = s_q.operation_success_flag;
        s_d.rdata[`FHV_DONE_BIT] = done;
        s_d.rdata[`FHV_RWE_BIT] = s_q.read_while_write_error;
        s_d.rdata[`FHV_MAS_BIT] = `FHV_MAS_CODE; // [RULE17]
        s_d.rdata[`FHV_LAS_LSB +: 3] = `FHV_LAS_CODE; // [RULE16]
        s_d.rdata[`FHV_SIZE_LSB +: 3] = `FHV_SIZE_CODE; // [RULE15]
      end else if (addr_i == `FHV_CFG_ADDR) begin
        s_d.rdata[`FHV_STALL_BIT] = s_q.stall_en;
        s_d.rdata[`FHV_ABORT_BIT] = s_q.abort_en;
        s_d.rdata[`FHV_IRQ_BIT] = s_q.irq_en;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_q <= '0; // [RULE7]
      s_q.operation_success_flag <= `FHV_PEG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign hv_pulse_o = s_q.hv_on;
  assign hv_erase_o = s_q.erase_select;
  assign hv_program_o = s_q.program_select;
  assign stall_o = s_q.stall;
  assign irq_o = s_q.irq;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_susp_report: assert property ( // [RULE1]
    (s_q.st == fhv_pkg::FHV_SUSP) |-> (s_q.erase_suspend_request && done))
    else $error("suspended without suspend bit and done");

  chk_erase_suspend_request_set_gate: assert property ( // [RULE2]
    $rose(s_q.erase_suspend_request) |-> $past(s_q.erase_select && s_q.high_voltage_enable && !s_q.program_select))
    else $error("suspend set without erase and enable");

  chk_susp_entry: assert property ( // [RULE3]
    $rose(s_q.erase_suspend_request) |-> (!done && s_q.cnt == `FHV_SUSP_LAT_CYC))
    else $error("suspend entry not started with latency count");

  chk_senter_end: assert property ( // [RULE3]
    (s_q.st == fhv_pkg::FHV_SENTER && s_q.cnt == 12'h000 && !fetch_collide_i)
      |=> (s_q.st == fhv_pkg::FHV_SUSP))
    else $error("suspend not reached at end of latency");

  chk_erase_suspend_request_clear_gate: assert property ( // [RULE4]
    $fell(s_q.erase_suspend_request) |-> $past(done && s_q.high_voltage_enable && !s_q.program_select))
    else $error("suspend cleared without done and enable");

  chk_resume_seq: assert property ( // [RULE5]
    ($fell(s_q.erase_suspend_request) && !fetch_collide_i)
      |-> (s_q.st == fhv_pkg::FHV_RESUME && !done))
    else $error("suspend release did not start resume");

  chk_susp_hold: assert property ( // [RULE6]
    (s_q.st == fhv_pkg::FHV_SUSP && !s_q.high_voltage_enable)
      |=> (s_q.st == fhv_pkg::FHV_SUSP && done && s_q.erase_suspend_request))
    else $error("left suspend with enable low");

  chk_ehv_set_gate: assert property ( // [RULE8]
    $rose(s_q.high_voltage_enable) |-> $past(ehv_ok || s_q.st == fhv_pkg::FHV_SUSP))
    else $error("enable set in illegal setup");

  chk_abort_peg: assert property ( // [RULE11]
    ($fell(s_q.high_voltage_enable) && $past(s_q.st == fhv_pkg::FHV_RUN))
      |-> (!s_q.operation_success_flag && done && !hv_pulse_o))
    else $error("abort did not clear success and pulse");

  chk_no_susp_abort: assert property ( // [RULE12]
    ($fell(s_q.high_voltage_enable) && $past(s_q.st == fhv_pkg::FHV_SUSP))
      |-> (s_q.st == fhv_pkg::FHV_SUSP))
    else $error("suspended operation aborted");

  chk_write_priority: assert property ( // [RULE18]
    (wr_mcr && w_ers != s_q.erase_select && w_pgm != s_q.program_select)
      |=> $stable(s_q.program_select) && $stable(s_q.high_voltage_enable))
    else $error("lower priority bit written with erase");

  chk_stall_out: assert property ( // [RULE19]
    (fetch_collide_i && busy && s_q.stall_en && !s_q.abort_en)
      |=> (stall_o && s_q.operation_success_flag))
    else $error("collision with stall enabled did not stall");

  chk_done_pulse: assert property ( // [RULE25]
    hv_pulse_o |-> (!done ##1 (!done || !hv_pulse_o)))
    else $error("done high while pulse runs");

endmodule : fhv_seq
`default_nettype wire

// ### rtl/fhv_defines.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef FHV_DEFINES_SVH
`define FHV_DEFINES_SVH

// register byte addresses
`define FHV_MCR_ADDR 8'h00
`define FHV_CFG_ADDR 8'h04

// module configuration field positions
`define FHV_EHV_BIT 0
`define FHV_ERASE_SUSPEND_REQUEST_BIT 1
`define FHV_ERS_BIT 2
`define FHV_PGM_BIT 4
`define FHV_PEG_BIT 9
`define FHV_DONE_BIT 10
`define FHV_RWE_BIT 15
`define FHV_MAS_BIT 16
`define FHV_LAS_LSB 20
`define FHV_SIZE_LSB 24

// stall/abort configuration field positions
`define FHV_STALL_BIT 0
`define FHV_ABORT_BIT 1
`define FHV_IRQ_BIT 2

// read-only geometry codes: 128 KB array, 32+2x16+2x32+128 KB low, 2x128 KB mid
`define FHV_SIZE_CODE 3'h0
`define FHV_LAS_CODE 3'h2
`define FHV_MAS_CODE 1'h0

// reset values
`define FHV_PEG_RST 1'h1

// timing
`define FHV_CLK_NS 5
`define FHV_SUSP_LAT_NS 15000
`define FHV_SUSP_LAT_CYC 12'(`FHV_SUSP_LAT_NS / `FHV_CLK_NS)
`define FHV_OP_CYC 12'h100
`define FHV_RES_CYC 12'h004

`endif

// ### rtl/fhv_pkg.sv
// types of the flash high-voltage sequencer
package fhv_pkg;

  typedef enum logic [2:0] {
    FHV_IDLE   = 3'h0,
    FHV_RUN    = 3'h1,
    FHV_SENTER = 3'h2,
    FHV_SUSP   = 3'h3,
    FHV_RESUME = 3'h4
  } fhv_state_e;

  typedef struct packed {
    fhv_state_e st;
    logic [11:0] cnt;
    logic [11:0] rem;
    logic high_voltage_enable;
    logic erase_suspend_request;
    logic erase_select;
    logic program_select;
    logic operation_success_flag;
    logic read_while_write_error;
    logic stall_en;
    logic abort_en;
    logic irq_en;
    logic hv_on;
    logic stall;
    logic irq;
    logic [31:0] rdata;
  } fhv_regs_s;

endpackage : fhv_pkg

// ### test/tb_top.sv
// self-checking bench for the flash high-voltage sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic array_integrity_enable_i = 1'b0;
  logic hv_fail_i = 1'b0;
  logic hv_pulse_o;
  logic hv_erase_o;
  logic hv_program_o;
  logic fetch_collide_i = 1'b0;
  logic stall_o;
  logic irq_o;
  int num_errors = 0;
  int tests_run = 0;
  int seed = 32'h3F110F09;
  logic [31:0] r;
  logic [7:0] a;
  localparam logic [31:0] HIGH_VOLTAGE_ENABLE = 32'h1;
  localparam logic [31:0] SUS = 32'h2;
  localparam logic [31:0] ERASE_SELECT = 32'h4;
  localparam logic [31:0] PROGRAM_SELECT = 32'h10;

  always #2.5 mclk_i = ~mclk_i;

  fhv_seq fhv_seq_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .array_integrity_enable_i(array_integrity_enable_i),
    .hv_fail_i(hv_fail_i), .hv_pulse_o(hv_pulse_o),
    .hv_erase_o(hv_erase_o), .hv_program_o(hv_program_o),
    .fetch_collide_i(fetch_collide_i), .stall_o(stall_o), .irq_o(irq_o)
  );

  // expected control word; geometry codes are fixed read-only fields
  function automatic logic [31:0] mcr(input logic e, s, x, p, g, d);
    mcr = {5'h0, 3'h0, 1'h0, 3'h2, 3'h0, 1'h0, 5'h0, d, g, 4'h0, p, 1'h0,
           x, s, e};
  endfunction : mcr

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic cmp(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data is only valid in the cycle right after the strobe
  task automatic rd(input logic [7:0] ad);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    r = rdata_o;
  endtask : rd

  // polls the done flag; each poll costs two cycles
  task automatic wait_done(input int bound);
    int n;
    n = 0;
    rd(8'h00);
    while (r[10] !== 1'b1 && n < bound) begin
      rd(8'h00);
      n++;
    end
    if (n >= bound) begin
      num_errors++;
      $display("[ERR] done expected 1 seen %b", r[10]);
      results();
    end
  endtask : wait_done

  task automatic wchk(input logic [31:0] d, input logic [31:0] exp);
    wr(8'h00, d);
    rd(8'h00);
    cmp("mcr", exp, r);
  endtask : wchk

  initial begin
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(8'h00);
    cmp("mcr", mcr(0, 0, 0, 0, 1, 1), r);
    rd(8'h04);
    cmp("cfg", 32'h0, r);
    wchk(HIGH_VOLTAGE_ENABLE, mcr(0, 0, 0, 0, 1, 1));
    wchk(SUS, mcr(0, 0, 0, 0, 1, 1));
    array_integrity_enable_i <= 1'b1;
    wchk(PROGRAM_SELECT, mcr(0, 0, 0, 0, 1, 1));
    array_integrity_enable_i <= 1'b0;
    wchk(ERASE_SELECT | PROGRAM_SELECT | HIGH_VOLTAGE_ENABLE, mcr(0, 0, 1, 0, 1, 1));
    wchk(ERASE_SELECT | HIGH_VOLTAGE_ENABLE, mcr(1, 0, 1, 0, 1, 0));
    cmp("hv", 32'h6, {29'h0, hv_pulse_o, hv_erase_o, hv_program_o});
    wchk(ERASE_SELECT | HIGH_VOLTAGE_ENABLE | SUS, mcr(1, 1, 1, 0, 1, 0));
    wait_done(1600);
    cmp("mcr", mcr(1, 1, 1, 0, 1, 1), r);
    wchk(ERASE_SELECT | SUS, mcr(0, 1, 1, 0, 1, 1));
    wchk(ERASE_SELECT, mcr(0, 1, 1, 0, 1, 1));
    wchk(ERASE_SELECT | SUS | HIGH_VOLTAGE_ENABLE, mcr(1, 1, 1, 0, 1, 1));
    wchk(ERASE_SELECT | HIGH_VOLTAGE_ENABLE, mcr(1, 0, 1, 0, 1, 0));
    wait_done(400);
    cmp("mcr", mcr(1, 0, 1, 0, 1, 1), r);
    wchk(ERASE_SELECT, mcr(0, 0, 1, 0, 1, 1));
    wchk(32'h0, mcr(0, 0, 0, 0, 1, 1));
    wr(8'h04, 32'h5);
    wchk(PROGRAM_SELECT, mcr(0, 0, 0, 1, 1, 1));
    wchk(PROGRAM_SELECT | HIGH_VOLTAGE_ENABLE, mcr(1, 0, 0, 1, 1, 0));
    @(posedge mclk_i);
    fetch_collide_i <= 1'b1;
    @(posedge mclk_i);
    fetch_collide_i <= 1'b0;
    #1;
    cmp("stall_irq", 32'h3, {30'h0, stall_o, irq_o});
    wchk(PROGRAM_SELECT, mcr(0, 0, 0, 1, 0, 1));
    wchk(32'h0, mcr(0, 0, 0, 0, 0, 1));
    // no stall/abort: a collision only flags the error, a failed pulse
    wr(8'h04, 32'h0);
    wchk(PROGRAM_SELECT, mcr(0, 0, 0, 1, 0, 1));
    wchk(PROGRAM_SELECT | HIGH_VOLTAGE_ENABLE, mcr(1, 0, 0, 1, 0, 0));
    hv_fail_i <= 1'b1;
    @(posedge mclk_i);
    fetch_collide_i <= 1'b1;
    @(posedge mclk_i);
    fetch_collide_i <= 1'b0;
    #1;
    cmp("stall_irq", 32'h0, {30'h0, stall_o, irq_o});
    wait_done(200);
    cmp("mcr", mcr(1, 0, 0, 1, 0, 1) | 32'h8000, r);
    wchk(PROGRAM_SELECT | 32'h8000, mcr(0, 0, 0, 1, 0, 1));
    hv_fail_i <= 1'b0;
    wchk(32'h0, mcr(0, 0, 0, 0, 0, 1));
    // unmapped places must read zero and ignore writes
    repeat (20) begin
      a = 8'($random(seed));
      if (a == 8'h00 || a == 8'h04) begin
        a = 8'h10;
      end
      wr(a, $random(seed));
      rd(a);
      cmp("unmapped", 32'h0, r);
    end
    rd(8'h00);
    cmp("mcr", mcr(0, 0, 0, 0, 0, 1), r);
    results();
  end
endmodule : tb_top

`default_nettype wire
